// File: rtl/selector_channel_service_logic.sv
/*
  Selector channel service logic: per-channel byte service, fair priority
  arbitration, and unit control word slot tables for block-multiplexed mode.
  Assumes one clock, synchronous inputs, and devices that hold a request
  until acknowledged.
*/
`timescale 1ns/1ps
`include "scsl_cfg.svh"

module scsl_fifo #(
  parameter int W = 8,
  parameter int D = `FIFO_DEPTH
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   fill;
  logic          push;
  logic          pop;

  assign in_ready  = (fill != (PW+1)'(D));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + PW'(1);
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : scsl_fifo

module selector_channel_service_logic #(
  parameter int NCH  = 4,
  parameter int AW   = 24,
  parameter int CW   = 16,
  parameter int POOL = 64
) (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    clk_en,
  input  wire logic [NCH-1:0]          svc_req,
  input  wire logic [2*NCH-1:0]        svc_kind,
  input  wire logic [8*NCH-1:0]        dev_byte,
  output logic      [NCH-1:0]          svc_ack,
  output logic      [NCH-1:0]          xfer_end,
  output logic      [`BYTE_W-1:0]      chan_byte,
  input  wire logic [NCH-1:0]          bmux_mode,
  input  wire logic [NCH-1:0]          disconnect,
  input  wire logic [2*NCH*32-1:0]     group_card,
  input  wire logic                    start_req,
  input  wire logic [3:0]              start_chan,
  input  wire logic [`DEV_W-1:0]       start_dev,
  input  wire logic [CW-1:0]           start_count,
  input  wire logic [AW-1:0]           start_addr,
  input  wire logic [`KEY_W-1:0]       start_key,
  output logic                         start_done,
  output logic      [1:0]              start_cc,
  output logic      [$clog2(POOL)-1:0] start_slot,
  output logic      [NCH-1:0]          chan_active,
  output logic                         init_busy,
  output logic                         fetch_req,
  output logic      [AW-1:0]           fetch_addr,
  output logic      [`KEY_W-1:0]       fetch_key,
  input  wire logic                    fetch_valid,
  input  wire logic [`BYTE_W-1:0]      fetch_data,
  output logic                         store_valid,
  input  wire logic                    store_ready,
  output logic      [AW-1:0]           store_addr,
  output logic      [`KEY_W-1:0]       store_key,
  output logic      [`BYTE_W-1:0]      store_data
);
  localparam int TBL = 1 << `GRP_BITS;
  localparam int NE  = NCH * TBL;
  localparam int SW  = $clog2(POOL);
  localparam int CH  = $clog2(NCH);
  localparam int EW  = $clog2(NE);
  localparam int FW  = AW + `KEY_W + `BYTE_W;

  function automatic logic [1:0] card_type(input logic [EW-1:0] e);
    card_type = group_card[2*e +: 2];
  endfunction : card_type

  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= '0;
    end else if (clk_en) begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [CW-1:0]       count [NCH];
  logic [AW-1:0]       addr  [NCH];
  logic [`KEY_W-1:0]   key   [NCH];
  logic                tbl_ok   [NE];
  logic [SW-1:0]       tbl_base [NE];
  logic [SW:0]         next_free;
  logic [EW-1:0]       init_idx;
  scsl_pkg::svc_state_e state;
  scsl_pkg::svc_kind_e  kind;
  logic [CH-1:0]       cur;
  logic [`BYTE_W-1:0]  cur_byte;
  logic [NCH-1:0]      blocked;
  logic                do_upd;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [FW-1:0]       fifo_out_data;

  // Arbitration: lowest number first, channels served while others wait are blocked.
  logic [NCH-1:0] pending;
  logic [NCH-1:0] eligible;
  logic [NCH-1:0] chosen_set;
  logic           grant_fire;
  logic [CH-1:0]  grant_idx;
  always_comb begin
    pending    = svc_req & chan_active & ~svc_ack;
    eligible   = pending & ~blocked;
    chosen_set = (eligible != '0) ? eligible : pending;
    grant_fire = (state == scsl_pkg::S_IDLE) && (pending != '0) && !init_busy;
    grant_idx  = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (chosen_set[i]) begin
        grant_idx = CH'(i);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocked <= '0;
    end else if (clk_en && grant_fire) begin
      if (eligible == '0) begin
        blocked <= '0;
      end
      if ((pending & ~(NCH'(1) << grant_idx)) != '0) begin
        blocked[grant_idx] <= 1'b1;
      end
    end
  end

  // Service sequencer: one request at a time; a write fetches before its update, a read updates when its byte enters the store buffer.
  always_comb begin
    fifo_in_valid = (state == scsl_pkg::S_EXEC) &&
                    (kind == scsl_pkg::K_RD_BACK || kind == scsl_pkg::K_RD_FWD);
    do_upd = 1'b0;
    case (state)
      scsl_pkg::S_EXEC: begin
        case (kind)
          scsl_pkg::K_SKIP:    do_upd = 1'b1;
          scsl_pkg::K_WRITE:   do_upd = 1'b0;
          default:             do_upd = fifo_in_ready;
        endcase
      end
      scsl_pkg::S_FETCH: do_upd = fetch_valid;
      default:           do_upd = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= scsl_pkg::S_IDLE;
      kind      <= scsl_pkg::K_SKIP;
      cur       <= '0;
      cur_byte  <= '0;
      fetch_req <= 1'b0;
      chan_byte <= '0;
    end else if (clk_en) begin
      case (state)
        scsl_pkg::S_IDLE: begin
          if (grant_fire) begin
            cur      <= grant_idx;
            kind     <= scsl_pkg::svc_kind_e'(svc_kind[2*grant_idx +: 2]);
            cur_byte <= dev_byte[8*grant_idx +: 8];
            state    <= scsl_pkg::S_EXEC;
          end
        end
        scsl_pkg::S_EXEC: begin
          if (kind == scsl_pkg::K_WRITE) begin
            fetch_req <= 1'b1;
            state     <= scsl_pkg::S_FETCH;
          end else if (do_upd) begin
            state <= scsl_pkg::S_IDLE;
          end
        end
        scsl_pkg::S_FETCH: begin
          if (fetch_valid) begin
            fetch_req <= 1'b0;
            chan_byte <= fetch_data;
            state     <= scsl_pkg::S_IDLE;
          end
        end
        default: state <= scsl_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr <= '0;
      fetch_key  <= '0;
    end else if (clk_en && state == scsl_pkg::S_EXEC) begin
      fetch_addr <= addr[cur];
      fetch_key  <= key[cur];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_ack  <= '0;
      xfer_end <= '0;
    end else if (clk_en) begin
      svc_ack  <= do_upd ? (NCH'(1) << cur) : '0;
      xfer_end <= (do_upd && count[cur] == CW'(`STEP)) ? (NCH'(1) << cur) : '0;
    end
  end

  // Start decode and unit control word table lookup.
  logic [CH-1:0]     s_ch;
  logic              s_valid;
  logic [EW-1:0]     s_ent;
  logic [1:0]        s_type;
  logic              s_alloc;
  logic [1:0]        s_cc;
  logic              s_take;
  always_comb begin
    s_valid = (start_chan >= `CHAN_FIRST) && (start_chan < `CHAN_FIRST + 4'(NCH));
    s_ch    = CH'(start_chan - `CHAN_FIRST);
    s_ent   = EW'({s_ch, start_dev[`DEV_W-1 -: `GRP_BITS]});
    s_type  = card_type(s_ent);
    s_alloc = 1'b0;
    s_cc    = `CC_OK;
    if (!s_valid) begin
      s_cc = `CC_NOT_OPER;
    end else if (init_busy || chan_active[s_ch]) begin
      s_cc = `CC_BUSY;
    end else if (bmux_mode[s_ch]) begin
      if (s_type == `GRP_PRIV && !tbl_ok[s_ent]) begin
        if (next_free + (SW+1)'(1 << `ROW_BITS) <= (SW+1)'(POOL)) begin
          s_alloc = 1'b1;
        end else begin
          s_cc = `CC_NOT_OPER;
        end
      end else if (!tbl_ok[s_ent]) begin
        s_cc = `CC_NOT_OPER;
      end
    end
    s_take = start_req && s_cc == `CC_OK;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_done <= 1'b0;
      start_cc   <= `CC_OK;
      start_slot <= '0;
    end else if (clk_en) begin
      start_done <= start_req;
      if (start_req) begin
        start_cc   <= s_cc;
        // A private entry owns a row, so each device of the entry takes its own slot in it.
        start_slot <= (s_alloc ? next_free[SW-1:0] : (s_valid ? tbl_base[s_ent] : '0)) +
                      ((s_type == `GRP_PRIV) ? SW'(start_dev[`ROW_BITS-1:0]) : '0);
      end
    end
  end

  // Per-channel operating registers; a start loads the started channel and a service updates only the serviced one.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_active <= '0;
      for (int i = 0; i < NCH; i++) begin
        count[i] <= '0;
        addr[i]  <= '0;
        key[i]   <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (bmux_mode[i] && disconnect[i] && !(state != scsl_pkg::S_IDLE && cur == CH'(i))) begin
          chan_active[i] <= 1'b0;
        end
      end
      if (s_take) begin
        chan_active[s_ch] <= 1'b1;
        count[s_ch]       <= start_count;
        addr[s_ch]        <= start_addr;
        key[s_ch]         <= start_key;
      end
      if (do_upd) begin
        count[cur] <= count[cur] - CW'(`STEP);
        if (kind == scsl_pkg::K_RD_BACK) begin
          addr[cur] <= addr[cur] - AW'(`STEP);
        end else if (kind != scsl_pkg::K_SKIP) begin
          addr[cur] <= addr[cur] + AW'(`STEP);
        end
        if (count[cur] == CW'(`STEP)) begin
          chan_active[cur] <= 1'b0;
        end
      end
    end
  end

  // Reset routine walks every table entry and places shared words.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_busy <= 1'b1;
      init_idx  <= '0;
      next_free <= '0;
      for (int e = 0; e < NE; e++) begin
        tbl_ok[e]   <= 1'b0;
        tbl_base[e] <= '0;
      end
    end else if (clk_en) begin
      if (init_busy) begin
        if (card_type(init_idx) == `GRP_SHARED && next_free < (SW+1)'(POOL)) begin
          tbl_ok[init_idx]   <= 1'b1;
          tbl_base[init_idx] <= next_free[SW-1:0];
          if (init_idx == EW'(NE - 1)) begin
            // A shared word in the last entry ends the walk, so the pool moves on to a fresh row.
            next_free <= {next_free[SW:`ROW_BITS] + (SW+1-`ROW_BITS)'(1), `ROW_BITS'(0)};
          end else begin
            next_free <= next_free + ((next_free[`ROW_BITS-1:0] == `SHARED_LAST) ?
                                      (SW+1)'(2) : (SW+1)'(1));
          end
        end else if (init_idx == EW'(NE - 1) && next_free[`ROW_BITS-1:0] != '0) begin
          next_free <= {next_free[SW:`ROW_BITS] + (SW+1-`ROW_BITS)'(1), `ROW_BITS'(0)};
        end
        if (init_idx == EW'(NE - 1)) begin
          init_busy <= 1'b0;
        end else begin
          init_idx <= init_idx + EW'(1);
        end
      end else if (s_take && s_alloc) begin
        tbl_ok[s_ent]   <= 1'b1;
        tbl_base[s_ent] <= next_free[SW-1:0];
        next_free       <= next_free + (SW+1)'(1 << `ROW_BITS);
      end
    end
  end

  scsl_fifo #(.W(FW), .D(`FIFO_DEPTH)) store_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr[cur], key[cur], cur_byte}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Output stage keeps the storage port driven from flip-flops.
  assign fifo_out_ready = !store_valid || store_ready;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_valid <= 1'b0;
      store_addr  <= '0;
      store_key   <= '0;
      store_data  <= '0;
    end else if (clk_en && fifo_out_ready) begin
      store_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        {store_addr, store_key, store_data} <= fifo_out_data;
      end
    end
  end

  chk_one_service: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $onehot0(svc_ack) && $onehot0(xfer_end)) else $error("more than one channel serviced");
  chk_no_repeat_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
    grant_fire |-> !svc_ack[grant_idx]) else $error("channel granted right after its service");
  chk_skip_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && do_upd && kind == scsl_pkg::K_SKIP |=> addr[$past(cur)] == $past(addr[cur])
    && !store_valid || $past(store_valid)) else $error("skip altered address");
  chk_back_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && do_upd && kind == scsl_pkg::K_RD_BACK |-> fifo_in_valid ##1
    addr[$past(cur)] == $past(addr[cur]) - AW'(1)) else $error("read backward update wrong");
  chk_fwd_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && do_upd && kind == scsl_pkg::K_RD_FWD |-> fifo_in_ready ##1
    addr[$past(cur)] == $past(addr[cur]) + AW'(1)) else $error("read forward update wrong");
  chk_write_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && do_upd && kind == scsl_pkg::K_WRITE |-> fetch_req ##1 chan_byte == $past(fetch_data))
    else $error("write updated without fetch");
  chk_count_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && do_upd && count[cur] == CW'(1) |=> xfer_end == svc_ack && !chan_active[$past(cur)])
    else $error("end of transfer missed");
  chk_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && start_req && s_valid && chan_active[s_ch] |=> start_done && start_cc == `CC_BUSY)
    else $error("start accepted on busy channel");
endmodule : selector_channel_service_logic

// File: inc/scsl_cfg.svh
/*
  Named constants for the selector channel service logic.
  Assumes inclusion by bare name from files that need it.
*/
`ifndef SCSL_CFG_SVH
`define SCSL_CFG_SVH
`define CC_OK        2'h0
`define CC_BUSY      2'h2
`define CC_NOT_OPER  2'h3
`define CHAN_FIRST   4'h1
`define GRP_NONE     2'h0
`define GRP_PRIV     2'h1
`define GRP_SHARED   2'h2
`define ROW_BITS     3
`define SHARED_LAST  3'h6
`define GRP_BITS     5
`define DEV_W        8
`define BYTE_W       8
`define KEY_W        4
`define FIFO_DEPTH   8
`define STEP         1
`endif

// File: inc/scsl_pkg.sv
/*
  Types shared by the selector channel service logic.
  Assumes no other package.
*/
package scsl_pkg;
  typedef enum logic [1:0] {K_SKIP, K_RD_BACK, K_RD_FWD, K_WRITE} svc_kind_e;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FETCH} svc_state_e;
endpackage : scsl_pkg

// File: dv/stor_model.sv
/*
  Main storage model facing the fetch and store ports of the service logic.
  Assumes the bench drives stall and reads the two logs by hierarchy.
*/
`timescale 1ns/1ps

module stor_model (
  input  wire logic        sys_clk,
  input  wire logic        stall,
  input  wire logic        fetch_req,
  input  wire logic [23:0] fetch_addr,
  input  wire logic [3:0]  fetch_key,
  output logic             fetch_valid,
  output logic      [7:0]  fetch_data,
  input  wire logic        store_valid,
  output logic             store_ready,
  input  wire logic [23:0] store_addr,
  input  wire logic [3:0]  store_key,
  input  wire logic [7:0]  store_data
);
  logic [35:0] st_q[$];
  logic [27:0] fe_q[$];
  int          wait_cnt = 0;

  initial begin
    fetch_valid = 1'b0;
    fetch_data  = 8'h00;
    store_ready = 1'b0;
  end

  // Reads answer late so the requester must hold its request; idle data keeps toggling.
  always @(negedge sys_clk) begin
    store_ready <= !stall;
    if (fetch_valid) begin
      fetch_valid <= 1'b0;
      fetch_data  <= ~fetch_data;
      wait_cnt    <= 0;
    end else if (fetch_req && wait_cnt == 2) begin
      fetch_valid <= 1'b1;
      fetch_data  <= fetch_addr[7:0] ^ 8'h5a;
      fe_q.push_back({fetch_key, fetch_addr});
    end else begin
      fetch_data <= ~fetch_data;
      if (fetch_req) wait_cnt <= wait_cnt + 1;
    end
  end

  always @(posedge sys_clk)
    if (store_valid && store_ready) st_q.push_back({store_key, store_addr, store_data});
endmodule : stor_model

// File: dv/tb_top.sv
/*
  Self-checking bench for the selector channel service logic.
  Assumes stor_model answers storage; the bench plays the devices.
*/
`timescale 1ns/1ps
`include "scsl_cfg.svh"

module tb_top;
  logic         sys_clk     = 1'b0;
  logic         nrst        = 1'b0;
  logic         stall       = 1'b0;
  logic [3:0]   svc_req     = 4'h0;
  logic [7:0]   svc_kind    = 8'h00;
  logic [31:0]  dev_byte    = 32'h0;
  logic [3:0]   bmux_mode   = 4'h2;
  logic [3:0]   disconnect  = 4'h0;
  logic [255:0] group_card  = 256'h0;
  logic         start_req   = 1'b0;
  logic [3:0]   start_chan  = 4'h0;
  logic [7:0]   start_dev   = 8'h00;
  logic [15:0]  start_count = 16'h0;
  logic [23:0]  start_addr  = 24'h0;
  logic [3:0]   svc_ack, xfer_end, chan_active, start_slot, fetch_key, store_key;
  logic [7:0]   chan_byte, fetch_data, store_data;
  logic [23:0]  fetch_addr, store_addr;
  logic [1:0]   start_cc;
  logic         start_done, init_busy, fetch_req, fetch_valid, store_valid, store_ready;
  int           error_cnt = 0;
  int           samples_checked = 0;
  int           pend[4] = '{default: 0};
  int           ends[4] = '{default: 0};
  logic [1:0]   ack_q[$];
  logic [7:0]   wb_q[$];

  always #4 sys_clk = ~sys_clk;

  selector_channel_service_logic #(.POOL(16)) uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
    .svc_req(svc_req), .svc_kind(svc_kind), .dev_byte(dev_byte), .svc_ack(svc_ack), .xfer_end(xfer_end),
    .chan_byte(chan_byte), .bmux_mode(bmux_mode), .disconnect(disconnect), .group_card(group_card),
    .start_req(start_req), .start_chan(start_chan), .start_dev(start_dev), .start_count(start_count),
    .start_addr(start_addr), .start_key(start_chan), .start_done(start_done), .start_cc(start_cc),
    .start_slot(start_slot), .chan_active(chan_active), .init_busy(init_busy), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_key(fetch_key), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .store_valid(store_valid), .store_ready(store_ready), .store_addr(store_addr), .store_key(store_key),
    .store_data(store_data));

  stor_model mem (.sys_clk(sys_clk), .stall(stall), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_key(fetch_key), .fetch_valid(fetch_valid), .fetch_data(fetch_data), .store_valid(store_valid),
    .store_ready(store_ready), .store_addr(store_addr), .store_key(store_key), .store_data(store_data));

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Devices raise one request per byte and drop it for a cycle after each acknowledge.
  always @(negedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (svc_ack[i]) begin
        pend[i]--;
        svc_req[i] = 1'b0;
        ack_q.push_back(2'(i));
        if (xfer_end[i]) ends[i]++;
        if (svc_kind[2*i+:2] == scsl_pkg::K_WRITE) wb_q.push_back(chan_byte);
      end else svc_req[i] = (pend[i] > 0);
      dev_byte[8*i+:8] = {4'(i), 4'(pend[i])};
    end
    cmp("acks per cycle", 32'h1, 32'($countones(svc_ack) <= 1));
  end

  task automatic start(input logic [3:0] ch, input logic [7:0] dev, input logic [15:0] cnt,
                       input logic [23:0] adr, input logic [1:0] cc);
    @(negedge sys_clk);
    start_req   = 1'b1;
    start_chan  = ch;
    start_dev   = dev;
    start_count = cnt;
    start_addr  = adr;
    @(negedge sys_clk);
    start_req = 1'b0;
    cmp("start done", 32'h1, 32'(start_done));
    cmp("start cc", 32'(cc), 32'(start_cc));
  endtask : start

  task automatic drain(input int i);
    int k;
    k = 0;
    while (pend[i] > 0 && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    cmp("drain in time", 32'h1, 32'(k < 300));
    repeat (6) @(negedge sys_clk);
  endtask : drain

  task automatic xfer(input int i, input scsl_pkg::svc_kind_e kind, input int n, input logic [23:0] adr);
    svc_kind[2*i+:2] = kind;
    ends[i] = 0;
    start(4'(i + 1), 8'h00, 16'(n), adr, `CC_OK);
    start(4'(i + 1), 8'h00, 16'(n), adr, `CC_BUSY);
    pend[i] = n;
    drain(i);
    cmp("end pulses", 32'h1, 32'(ends[i]));
    cmp("channel idle", 32'h0, 32'(chan_active[i]));
  endtask : xfer

  task automatic chk_st(input int i, input logic [23:0] a0, input int step, input int n);
    cmp("store count", 32'(n), 32'(mem.st_q.size()));
    for (int j = 0; j < n && j < mem.st_q.size(); j++)
      cmp("store entry", {4'(i + 1), a0 + 24'(step * j)}, mem.st_q[j][35:8]);
    for (int j = 0; j < n && j < mem.st_q.size(); j++)
      cmp("store byte", {4'(i), 4'(n - j)}, 32'(mem.st_q[j][7:0]));
    mem.st_q.delete();
  endtask : chk_st

  task automatic t_init();
    cmp("init busy in reset", 32'h1, 32'(init_busy));
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    start(4'h1, 8'h00, 16'h1, 24'h0, `CC_BUSY);
    repeat (160) @(negedge sys_clk);
    cmp("init done", 32'h0, 32'(init_busy));
    start(4'h0, 8'h00, 16'h1, 24'h0, `CC_NOT_OPER);
    start(4'h5, 8'h00, 16'h1, 24'h0, `CC_NOT_OPER);
    $display("init test finished");
  endtask : t_init

  task automatic t_kinds();
    xfer(0, scsl_pkg::K_RD_FWD, 3, 24'h001000);
    chk_st(0, 24'h001000, 1, 3);
    xfer(2, scsl_pkg::K_RD_BACK, 2, 24'h002000);
    chk_st(2, 24'h002000, -1, 2);
    xfer(0, scsl_pkg::K_SKIP, 2, 24'h002800);
    cmp("skip stores", 32'h0, 32'(mem.st_q.size()));
    cmp("skip fetches", 32'h0, 32'(mem.fe_q.size()));
    wb_q.delete();
    xfer(3, scsl_pkg::K_WRITE, 2, 24'h0030f0);
    cmp("write fetches", 32'h2, 32'(mem.fe_q.size()));
    cmp("write acks", 32'h2, 32'(wb_q.size()));
    for (int j = 0; j < 2 && j < wb_q.size() && j < mem.fe_q.size(); j++) begin
      cmp("fetch entry", {4'h4, 24'h0030f0 + 24'(j)}, 32'(mem.fe_q[j]));
      cmp("write byte", 32'(8'hf0 + 8'(j) ^ 8'h5a), 32'(wb_q[j]));
    end
    cmp("write stores", 32'h0, 32'(mem.st_q.size()));
    $display("service kinds test finished");
  endtask : t_kinds

  task automatic t_fair();
    logic [1:0] exp_q[$] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
    svc_kind = 8'h00;
    svc_kind[1:0] = scsl_pkg::K_RD_FWD;
    svc_kind[5:4] = scsl_pkg::K_RD_FWD;
    svc_kind[7:6] = scsl_pkg::K_RD_FWD;
    start(4'h1, 8'h00, 16'h3, 24'h005000, `CC_OK);
    start(4'h3, 8'h00, 16'h1, 24'h006000, `CC_OK);
    start(4'h4, 8'h00, 16'h1, 24'h007000, `CC_OK);
    ack_q.delete();
    pend = '{3, 0, 1, 1};
    drain(0);
    cmp("ack total", 32'h5, 32'(ack_q.size()));
    for (int j = 0; j < 5 && j < ack_q.size(); j++)
      cmp("grant order", 32'(exp_q[j]), 32'(ack_q[j]));
    mem.st_q.delete();
    $display("arbitration test finished");
  endtask : t_fair

  task automatic t_fifo();
    svc_kind[1:0] = scsl_pkg::K_RD_FWD;
    stall = 1'b1;
    start(4'h1, 8'h00, 16'hc, 24'h004000, `CC_OK);
    pend[0] = 12;
    repeat (60) @(negedge sys_clk);
    cmp("stalled at full buffer", 32'h1, 32'(pend[0] > 0 && pend[0] <= 4));
    stall = 1'b0;
    drain(0);
    chk_st(0, 24'h004000, 1, 12);
    $display("buffer test finished");
  endtask : t_fifo

  task automatic disc();
    @(negedge sys_clk);
    disconnect[1] = 1'b1;
    repeat (2) @(negedge sys_clk);
    disconnect[1] = 1'b0;
  endtask : disc

  task automatic t_bmux();
    logic [3:0] s0;
    group_card[65:64] = `GRP_PRIV;
    group_card[67:66] = `GRP_SHARED;
    group_card[71:70] = `GRP_PRIV;
    nrst = 1'b0;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (160) @(negedge sys_clk);
    start(4'h2, 8'h03, 16'h4, 24'h0, `CC_OK);
    s0 = start_slot;
    disc();
    start(4'h2, 8'h05, 16'h4, 24'h0, `CC_OK);
    cmp("slot in row", 32'(s0 + 4'h2), 32'(start_slot));
    disc();
    start(4'h2, 8'h10, 16'h4, 24'h0, `CC_NOT_OPER);
    start(4'h2, 8'h08, 16'h4, 24'h0, `CC_OK);
    start(4'h2, 8'h18, 16'h4, 24'h0, `CC_BUSY);
    disc();
    start(4'h2, 8'h18, 16'h4, 24'h0, `CC_NOT_OPER);
    $display("block mode test finished");
  endtask : t_bmux

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(negedge sys_clk);
    t_init();
    t_kinds();
    t_fair();
    t_fifo();
    t_bmux();
    test_done();
  end

  // The tests need under 2000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_top
